// ### rtl/iop_cfg.svh
// Constants for the two general-purpose I/O ports and their APB window.
// Assumes a 32-bit APB master; only the low byte lane of each word is used.
`ifndef IOP_CFG_SVH
`define IOP_CFG_SVH

`define IOP_ADDR_W        12
`define IOP_OFS_C_PIN     12'h000
`define IOP_OFS_C_LAT     12'h004
`define IOP_OFS_C_DIR     12'h008
`define IOP_OFS_D_PIN     12'h00C
`define IOP_OFS_D_LAT     12'h010
`define IOP_OFS_D_DIR     12'h014
`define IOP_OFS_E_CTL     12'h018

`define IOP_DIR_RST       8'hFF
`define IOP_E_CTL_RST     8'h07
`define IOP_E_DIR_RST     3'h7
`define IOP_LAT_POR       8'h00
`define IOP_C_PIN_MASK    8'hF9

`define IOP_E_IBF_BIT     7
`define IOP_E_OBF_BIT     6
`define IOP_E_INPUT_BUFFER_OVERFLOW_FLAG_BIT    5
`define IOP_E_MODE_BIT    4
`define IOP_E_DIR_MASK    8'h17

`endif

// ### rtl/iop_pkg.sv
// Types for the two-port I/O block.
// Assumes iop_cfg.svh is visible on the include path.
package iop_pkg;
  typedef logic [7:0] iop_byte_t;

  // State that the ordinary reset (presetn) sets; por_n alone leaves it
  typedef struct packed {
    iop_byte_t c_dir;
    iop_byte_t d_dir;
    iop_byte_t e_ctl;
    iop_byte_t c_pin;
    iop_byte_t d_pin;
    iop_byte_t c_out;
    iop_byte_t c_oe_n;
    iop_byte_t d_out;
    iop_byte_t d_oe_n;
    logic [2:0] e_dir;
    logic       slave_mode;
    logic       pready;
    logic       pslverr;
    logic [31:0] prdata;
  } iop_ctl_t;

  // Output latches, cleared only by power-on reset
  typedef struct packed {
    iop_byte_t c_lat;
    iop_byte_t d_lat;
  } iop_lat_t;
endpackage : iop_pkg

// ### rtl/iop_ports.sv
// Two general-purpose I/O ports (six-pin port C, eight-pin port D) plus
// the port E direction and slave-port mode register, on an APB slave.
// Assumes pin inputs and peripheral controls are synchronous to pclk and
// that the slave-port handshake logic lives outside this block.
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/1ns
`include "iop_cfg.svh"

module iop_ports (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  por_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [`IOP_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire iop_pkg::iop_byte_t    port_c_in,
  output iop_pkg::iop_byte_t         port_c_out,
  output iop_pkg::iop_byte_t         port_c_oe_n,
  input  wire iop_pkg::iop_byte_t    port_c_periph_sel,
  input  wire iop_pkg::iop_byte_t    port_c_periph_drive,
  input  wire iop_pkg::iop_byte_t    port_c_periph_out,
  input  wire iop_pkg::iop_byte_t    port_d_in,
  output iop_pkg::iop_byte_t         port_d_out,
  output iop_pkg::iop_byte_t         port_d_oe_n,
  input  wire iop_pkg::iop_byte_t    parallel_slave_port_out,
  input  wire logic                  parallel_slave_port_drive,
  input  wire logic                  input_buffer_full_flag,
  input  wire logic                  output_buffer_full_flag,
  input  wire logic                  input_buffer_overflow_set,
  output logic [2:0]                 port_e_dir,
  output logic                       parallel_slave_mode_select
);
  import iop_pkg::*;

  // A literal cannot be bit-selected, so the pin mask is held by name
  localparam iop_byte_t c_pin_mask = `IOP_C_PIN_MASK;

  iop_ctl_t ctl_ff;
  iop_ctl_t nxt_ctl;
  iop_lat_t lat_ff;
  iop_lat_t nxt_lat;

  logic      setup;
  logic      wr_en;
  logic      hit;
  iop_byte_t wbyte;
  iop_byte_t rbyte;
  iop_byte_t c_oe_n_w;
  iop_byte_t c_out_w;
  iop_byte_t d_oe_n_w;
  iop_byte_t d_out_w;

  assign setup = psel && !penable;
  // Writes land only on the completing edge, with the low lane enabled
  assign wr_en = psel && penable && ctl_ff.pready && pwrite && pstrb[0];
  assign wbyte = pwdata[7:0];

  // Address decode for read data and the error answer
  always_comb begin
    hit   = 1'b1;
    rbyte = 8'h00;
    unique case (paddr)
      `IOP_OFS_C_PIN: rbyte = ctl_ff.c_pin;
      `IOP_OFS_C_LAT: rbyte = lat_ff.c_lat;
      `IOP_OFS_C_DIR: rbyte = ctl_ff.c_dir;
      `IOP_OFS_D_PIN: rbyte = ctl_ff.d_pin;
      `IOP_OFS_D_LAT: rbyte = lat_ff.d_lat;
      `IOP_OFS_D_DIR: rbyte = ctl_ff.d_dir;
      `IOP_OFS_E_CTL: rbyte = ctl_ff.e_ctl;
      default:        hit   = 1'b0;
    endcase
  end

  // Per-pin driver choice; stored direction is only read, never rewritten
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      always_comb begin
        if (!c_pin_mask[gi]) begin
          // No general-purpose pin sits at these bit positions
          c_oe_n_w[gi] = 1'b1;
          c_out_w[gi]  = 1'b0;
        end else if (port_c_periph_sel[gi]) begin
          // Serial, uart and timer functions share these pins
          c_oe_n_w[gi] = !port_c_periph_drive[gi];
          c_out_w[gi]  = port_c_periph_out[gi];
        end else begin
          c_oe_n_w[gi] = ctl_ff.c_dir[gi];
          c_out_w[gi]  = lat_ff.c_lat[gi];
        end
        if (ctl_ff.slave_mode) begin
          d_oe_n_w[gi] = !parallel_slave_port_drive;
          d_out_w[gi]  = parallel_slave_port_out[gi];
        end else begin
          d_oe_n_w[gi] = ctl_ff.d_dir[gi];
          d_out_w[gi]  = lat_ff.d_lat[gi];
        end
      end
    end
  endgenerate

  always_comb begin
    nxt_ctl = ctl_ff;
    nxt_lat = lat_ff;
    // Pins are sampled every cycle whatever their direction
    nxt_ctl.c_pin  = port_c_in & `IOP_C_PIN_MASK;
    nxt_ctl.d_pin  = port_d_in;
    nxt_ctl.c_out  = c_out_w;
    nxt_ctl.c_oe_n = c_oe_n_w;
    nxt_ctl.d_out  = d_out_w;
    nxt_ctl.d_oe_n = d_oe_n_w;
    // Zero-wait slave: answer is prepared in the setup cycle
    nxt_ctl.pready  = setup;
    nxt_ctl.pslverr = setup && !hit;
    nxt_ctl.prdata  = (setup && !pwrite) ? {24'h000000, rbyte} : 32'h0;
    if (wr_en) begin
      unique case (paddr)
        `IOP_OFS_C_PIN, `IOP_OFS_C_LAT: nxt_lat.c_lat = wbyte;
        `IOP_OFS_C_DIR: nxt_ctl.c_dir = wbyte;
        `IOP_OFS_D_PIN, `IOP_OFS_D_LAT: nxt_lat.d_lat = wbyte;
        `IOP_OFS_D_DIR: nxt_ctl.d_dir = wbyte;
        `IOP_OFS_E_CTL: begin
          nxt_ctl.e_ctl = (ctl_ff.e_ctl & ~`IOP_E_DIR_MASK)
                        | (wbyte & `IOP_E_DIR_MASK);
          // Overflow is cleared by writing zero to it
          if (!wbyte[`IOP_E_INPUT_BUFFER_OVERFLOW_FLAG_BIT]) begin
            nxt_ctl.e_ctl[`IOP_E_INPUT_BUFFER_OVERFLOW_FLAG_BIT] = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Status bits follow the slave port; a new overflow beats a clear
    nxt_ctl.e_ctl[`IOP_E_IBF_BIT] = input_buffer_full_flag;
    nxt_ctl.e_ctl[`IOP_E_OBF_BIT] = output_buffer_full_flag;
    if (input_buffer_overflow_set) begin
      nxt_ctl.e_ctl[`IOP_E_INPUT_BUFFER_OVERFLOW_FLAG_BIT] = 1'b1;
    end
    nxt_ctl.e_dir      = nxt_ctl.e_ctl[2:0];
    nxt_ctl.slave_mode = nxt_ctl.e_ctl[`IOP_E_MODE_BIT];
  end

  // Reset state: all pins input, no answer pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_ff        <= '0;
      ctl_ff.c_dir  <= `IOP_DIR_RST;
      ctl_ff.d_dir  <= `IOP_DIR_RST;
      ctl_ff.e_ctl  <= `IOP_E_CTL_RST;
      ctl_ff.e_dir  <= `IOP_E_DIR_RST;
      ctl_ff.c_oe_n <= `IOP_DIR_RST;
      ctl_ff.d_oe_n <= `IOP_DIR_RST;
    end else begin
      ctl_ff <= nxt_ctl;
    end
  end

  // Latches ride through ordinary resets; only power-on clears them
  always_ff @(posedge pclk or negedge por_n) begin
    if (!por_n) begin
      lat_ff <= {`IOP_LAT_POR, `IOP_LAT_POR};
    end else if (presetn) begin
      lat_ff <= nxt_lat;
    end
  end

  assign prdata                     = ctl_ff.prdata;
  assign pready                     = ctl_ff.pready;
  assign pslverr                    = ctl_ff.pslverr;
  assign port_c_out                 = ctl_ff.c_out;
  assign port_c_oe_n                = ctl_ff.c_oe_n;
  assign port_d_out                 = ctl_ff.d_out;
  assign port_d_oe_n                = ctl_ff.d_oe_n;
  assign port_e_dir                 = ctl_ff.e_dir;
  assign parallel_slave_mode_select = ctl_ff.slave_mode;
endmodule : iop_ports

// ### tb/iop_monitor.sv
// Protocol and pin checks for iop_ports, bound onto its ports.
// Assumes pins and pready are registered one cycle after their cause.
`timescale 1ns/1ns
module iop_monitor (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic [31:0]        prdata,
  input wire iop_pkg::iop_byte_t port_c_out,
  input wire iop_pkg::iop_byte_t port_c_oe_n,
  input wire iop_pkg::iop_byte_t port_c_periph_sel,
  input wire iop_pkg::iop_byte_t port_c_periph_drive,
  input wire iop_pkg::iop_byte_t port_d_out,
  input wire iop_pkg::iop_byte_t port_d_oe_n,
  input wire iop_pkg::iop_byte_t parallel_slave_port_out,
  input wire logic               parallel_slave_port_drive,
  input wire logic               parallel_slave_mode_select
);
  import iop_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup; psel && !penable; endsequence
  property p_ack; s_setup |=> pready; endproperty
  property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_c_res; port_c_oe_n[2:1] == 2'h3 && port_c_out[2:1] == 2'h0;
  endproperty
  property p_c_ovr; $past(presetn) |-> ((port_c_oe_n ^
    ~$past(port_c_periph_drive)) & $past(port_c_periph_sel) & 8'hF9) == 8'h00;
  endproperty
  property p_d_psp; $past(presetn) && $past(parallel_slave_mode_select) |->
    port_d_oe_n == {8{!$past(parallel_slave_port_drive)}}; endproperty
  property p_d_dat; $past(presetn) && $past(parallel_slave_mode_select &&
    parallel_slave_port_drive) |-> port_d_out == $past(parallel_slave_port_out);
  endproperty
  property p_rst; $rose(presetn) |-> port_c_oe_n == 8'hFF &&
    port_d_oe_n == 8'hFF && !parallel_slave_mode_select; endproperty
  a_ack: assert property (p_ack) else $error("access not answered");
  a_err: assert property (p_err) else $error("error answer carries data");
  a_idle: assert property (p_idle) else $error("read data outside answer");
  a_c_res: assert property (p_c_res) else $error("reserved pin driven");
  a_c_ovr: assert property (p_c_ovr) else $error("override ignored");
  a_d_psp: assert property (p_d_psp) else $error("slave enable bad");
  a_d_dat: assert property (p_d_dat) else $error("slave data bad");
  a_rst: assert property (p_rst) else $error("pins not input at reset");
endmodule : iop_monitor
bind iop_ports iop_monitor u_mon (.*);

// ### tb/iop_pins.sv
// Pad model: the outside world drives a pin whenever the block releases it.
// Assumes enables are active low, as the block drives them.
`timescale 1ns/1ns
module iop_pins (
  input  wire iop_pkg::iop_byte_t drv_val,
  input  wire iop_pkg::iop_byte_t oe_n,
  input  wire iop_pkg::iop_byte_t ext,
  output iop_pkg::iop_byte_t      pin
);
  import iop_pkg::*;
  assign pin = (oe_n & ext) | (~oe_n & drv_val);
endmodule : iop_pins

// ### tb/iop_ports_bench.sv
// Self-checking bench for iop_ports with an APB master and a register model.
// Assumes the one-cycle answer and one-cycle pin lag of the block.
`timescale 1ns/1ns
module iop_ports_bench;
  import iop_pkg::*;
  logic pclk = 0, presetn = 0, por_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, v, seed = 32'hFD46E344;
  logic [3:0] pstrb = 4'hF;
  logic pready, pslverr, er, parallel_slave_port_drive = 0;
  logic parallel_slave_mode_select, input_buffer_overflow_set = 0;
  logic input_buffer_full_flag = 0, output_buffer_full_flag = 0;
  logic [2:0] port_e_dir;
  iop_byte_t port_c_in, port_c_out, port_c_oe_n, port_d_in, port_d_out;
  iop_byte_t port_d_oe_n, ext_c = '0, ext_d = '0, parallel_slave_port_out = '0;
  iop_byte_t port_c_periph_sel = '0, port_c_periph_drive = '0;
  iop_byte_t port_c_periph_out = '0, lc, dc, ld, dd, ec;
  int fails = 0, checks = 0, cyc = 0;
  iop_ports u_dut (.*);
  iop_pins u_pc (.drv_val(port_c_out), .oe_n(port_c_oe_n), .ext(ext_c),
    .pin(port_c_in));
  iop_pins u_pd (.drv_val(port_d_out), .oe_n(port_d_oe_n), .ext(ext_d),
    .pin(port_d_in));
  always #4 pclk = ~pclk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task summarize();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task rdall();
    iop_byte_t eoc, euc, eod, eud, ex [7];
    eoc = (port_c_periph_sel & ~port_c_periph_drive | ~port_c_periph_sel & dc);
    eoc = eoc | 8'h06;
    euc = port_c_periph_sel & port_c_periph_out | ~port_c_periph_sel & lc;
    eod = ec[4] ? {8{~parallel_slave_port_drive}} : dd;
    eud = ec[4] ? parallel_slave_port_out : ld;
    ex = '{(ext_c & eoc | euc & ~eoc) & 8'hF9, lc, dc, ext_d & eod | eud & ~eod,
      ld, dd, {input_buffer_full_flag, output_buffer_full_flag, 1'b0, ec[4],
      1'b0, ec[2:0]}};
    repeat (3) @(negedge pclk);
    chk(port_c_oe_n, eoc);
    chk(port_c_out & ~eoc, euc & ~eoc);
    chk(port_d_oe_n, eod);
    chk(port_d_out & ~eod, eud & ~eod);
    chk(parallel_slave_mode_select, ec[4]);
    chk(port_e_dir, ec[2:0]);
    for (int k = 0; k < 7; k++) begin
      xfer(1'b0, 12'(4 * k), 8'h00);
      chk(rd, {24'h0, ex[k]});
    end
  endtask : rdall
  initial begin
    {lc, ld, dc, dd, ec} = {16'h0000, 16'hFFFF, 8'h07};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    rdall();
    for (int it = 0; it < 40; it++) begin
      v = xs();
      {port_c_periph_out, port_c_periph_drive, ext_d, ext_c} <= v;
      v = xs();
      port_c_periph_sel <= v[7:0] & 8'hF9 & {8{it[1]}};
      parallel_slave_port_out <= v[15:8];
      {output_buffer_full_flag, input_buffer_full_flag} <= v[18:17];
      parallel_slave_port_drive <= v[16];
      v = xs();
      // Reserved bits keep their reset value so they are never disturbed
      {dd, ld, dc, lc} = v | 32'h0006_0000 & 32'hFFFF_FFF9;
      dc = dc | 8'h06;
      lc = lc & 8'hF9;
      v = xs();
      ec = v[7:0] & 8'h17;
      xfer(1'b1, it[0] ? 12'h000 : 12'h004, lc);
      xfer(1'b1, 12'h008, dc);
      xfer(1'b1, it[0] ? 12'h00C : 12'h010, ld);
      xfer(1'b1, 12'h014, dd);
      xfer(1'b1, 12'h018, ec);
      rdall();
    end
    port_c_periph_sel <= '0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    {dc, dd, ec} = 24'hFFFF07;
    rdall();
    // Overflow pulse sets the status bit; writing zero clears it
    input_buffer_overflow_set <= 1'b1;
    @(posedge pclk);
    input_buffer_overflow_set <= 1'b0;
    xfer(1'b0, 12'h018, 8'h00);
    chk(rd[5], 1'b1);
    xfer(1'b1, 12'h018, 8'h07);
    xfer(1'b0, 12'h018, 8'h00);
    chk(rd[5], 1'b0);
    // A write without the low byte lane must leave the register alone
    pstrb <= 4'hE;
    xfer(1'b1, 12'h008, 8'h00);
    pstrb <= 4'hF;
    xfer(1'b0, 12'h008, 8'h00);
    chk(rd, 32'h0000_00FF);
    xfer(1'b1, 12'h01C, 8'h5A);
    chk(er, 1'b1);
    xfer(1'b0, 12'h01C, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    summarize();
  end
endmodule : iop_ports_bench
